/* File: hdl/amx_consts.svh */
// constants of the auxiliary microphone to adc mix level block
`ifndef AMX_CONSTS_SVH
`define AMX_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define AMX_IDX_LEFT      8'h11
`define AMX_IDX_RIGHT     8'h12
`define AMX_IDX_STATUS    8'h20

// widths
`define AMX_DATA_W        32
`define AMX_REG_W         8
`define AMX_LVL_W         4
`define AMX_ATTEN_W       5
`define AMX_NPATH         4

// field positions inside a mix level register
`define AMX_HI_LSB        4
`define AMX_LO_LSB        0

// path numbering used on the decoded outputs
`define AMX_PATH_LL       0
`define AMX_PATH_RL       1
`define AMX_PATH_LR       2
`define AMX_PATH_RR       3

// level codes
`define AMX_CODE_MAX      4'h8
`define AMX_CODE_OFF      4'hF
`define AMX_REG_RST       8'hFF

// one code step is 1.5 dB, i.e. three half-dB units
`define AMX_STEP_HALF_DB  5'h03

// status register field positions
`define AMX_ST_CONN_LSB   0
`define AMX_ST_RSVD_LSB   4

`endif

/* File: hdl/amx_pkg.sv */
// types of the auxiliary microphone to adc mix level block
`include "amx_consts.svh"

package amx_pkg;

	typedef logic [`AMX_NPATH-1:0][`AMX_LVL_W-1:0]   amx_code_vec_type;
	typedef logic [`AMX_NPATH-1:0][`AMX_ATTEN_W-1:0] amx_atten_vec_type;

	// complete state of the register block
	typedef struct packed {
		logic [`AMX_REG_W-1:0]  lvl_left;
		logic [`AMX_REG_W-1:0]  lvl_right;
		logic [`AMX_DATA_W-1:0] prdata;
		logic                   pready;
		logic                   pslverr;
		logic [`AMX_NPATH-1:0]  connect;
		amx_atten_vec_type      atten;
		logic [`AMX_NPATH-1:0]  reserved;
	} amx_state_type;

endpackage

/* File: hdl/amx_lvl_if.sv */
// carrier between the register block and the level decoder
`include "amx_consts.svh"

interface amx_lvl_if;
	amx_pkg::amx_code_vec_type  code;
	logic [`AMX_NPATH-1:0]      connect;
	amx_pkg::amx_atten_vec_type atten;
	logic [`AMX_NPATH-1:0]      reserved;

	modport regs (
		output code,
		input  connect,
		input  atten,
		input  reserved
	);

	modport dec (
		input  code,
		output connect,
		output atten,
		output reserved
	);
endinterface

/* File: hdl/amx_level_decode.sv */
// decoder from level codes to connect and attenuation per mix path
`include "amx_consts.svh"

module amx_level_decode (
	amx_lvl_if.dec lvl
);

	// code 0..8 connects with 1.5 dB per step, 1111 and reserved cut off
	always_comb begin
		for (int i = 0; i < `AMX_NPATH; i++) begin
			lvl.connect[i]  = (lvl.code[i] <= `AMX_CODE_MAX);
			lvl.reserved[i] = (lvl.code[i] > `AMX_CODE_MAX) &&
				(lvl.code[i] != `AMX_CODE_OFF);
			if (lvl.code[i] <= `AMX_CODE_MAX) begin
				lvl.atten[i] = `AMX_ATTEN_W'(lvl.code[i] *
					`AMX_STEP_HALF_DB);
			end else begin
				lvl.atten[i] = '0;
			end
		end
	end

endmodule // amx_level_decode

/* File: hdl/amx_mix_levels.sv */
// apb register block for auxiliary microphone to adc mix levels
// register map, one 8-bit register per aligned 32-bit word
//   index 0x11, byte 0x44: levels into the left adc mix
//   index 0x12, byte 0x48: levels into the right adc mix
//   index 0x20, byte 0x80: read-only decode status
//   any other address answers with pslverr and zero data
//
// level register layout
//   bits 7:4 level code of the left auxiliary microphone
//   bits 3:0 level code of the right auxiliary microphone
//   bits 31:8 of a write are dropped and read back as zero
//
// level code meaning
//   0000 to 1000 connect the input, 1.5 dB more cut per step
//   1001 to 1110 reserved: stored, but decoded as cut off
//   1111 input cut off from that mix, also the reset value
//
// decoded outputs
//   mix_connect bit 0: left mic into the left mix
//   mix_connect bit 1: right mic into the left mix
//   mix_connect bit 2: left mic into the right mix
//   mix_connect bit 3: right mic into the right mix
//   attenuation outputs count half-dB units, code times 3
//   a cut-off path shows attenuation zero, not a full cut
//   so the mixer must gate on mix_connect, not on the level
//
// status register layout
//   bits 3:0 copy of mix_connect
//   bits 7:4 set where a path holds a reserved code
//   writes to it complete without error and change nothing
//
// bus timing
//   setup cycle: psel high, penable low
//   access cycle: pready high for exactly one cycle
//   read data and pslverr are prepared at the setup edge
//   a write lands at the access edge, with pready high
//   only pstrb[0] qualifies a write; pstrb[3:1] are unused
//   back-to-back transfers need no idle cycle between them
//   prdata and pslverr drop to zero after the access cycle
//
// output timing
//   a level register changes at the access edge
//   decoded outputs follow at the next rising edge
//   so a new level shows one edge after the access edge
//
// reset
//   presetn low clears at once, without waiting for pclk
//   both level registers come back as all ones
//   all paths start cut off, with attenuation zero
//   bus outputs stay low until the first setup cycle
//
// hazards and limits
//   read data is taken from the registers at setup time
//   a read straight behind a write to the same register
//   still sees the new value, since the store came first
//   reserved codes are kept so software can read back its slip
//   codes above 1000 never reach the attenuation outputs
//   the decoder is pure logic; its result is registered here
//   the extra decode stage keeps every output on a flop
//   a write to an unmapped address is dropped with pslverr
//   pslverr is low whenever no transfer is in its access cycle
//   an ADDR_W below 8 would alias the register addresses
//   the status register is never written by the bus
//
// Register access over APB is this design's own decision.
`include "amx_consts.svh"

module amx_mix_levels #(
	parameter int ADDR_W = 12
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_W-1:0]       paddr,
	input  wire logic [`AMX_DATA_W-1:0]  pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [`AMX_DATA_W-1:0]  prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic      [`AMX_NPATH-1:0]   mix_connect,
	output logic      [`AMX_ATTEN_W-1:0] left_adc_from_left_mic_atten,
	output logic      [`AMX_ATTEN_W-1:0] left_adc_from_right_mic_atten,
	output logic      [`AMX_ATTEN_W-1:0] right_adc_from_left_mic_atten,
	output logic      [`AMX_ATTEN_W-1:0] right_adc_from_right_mic_atten
);

	amx_pkg::amx_state_type st_r;
	amx_pkg::amx_state_type st_nxt;
	amx_lvl_if              lvl ();
	logic                   setup;
	logic                   access;
	logic                   hit_left;
	logic                   hit_right;
	logic                   hit_status;
	logic                   wr_byte0;
	logic [`AMX_REG_W-1:0]  status_val;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] byte_addr(
		input logic [`AMX_REG_W-1:0] idx
	);
		return ADDR_W'({idx, 2'h0});
	endfunction

	// true when the bus address selects the register of that index
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0]     a,
		input logic [`AMX_REG_W-1:0] idx
	);
		return a == byte_addr(idx);
	endfunction

	// upper and lower level nibble of a register
	function automatic logic [`AMX_LVL_W-1:0] hi_field(
		input logic [`AMX_REG_W-1:0] r
	);
		return r[`AMX_HI_LSB +: `AMX_LVL_W];
	endfunction

	function automatic logic [`AMX_LVL_W-1:0] lo_field(
		input logic [`AMX_REG_W-1:0] r
	);
		return r[`AMX_LO_LSB +: `AMX_LVL_W];
	endfunction

	// bus phases and address decode
	assign setup      = psel & ~penable;
	assign access     = psel & penable & st_r.pready;
	assign hit_left   = addr_hit(paddr, `AMX_IDX_LEFT);
	assign hit_right  = addr_hit(paddr, `AMX_IDX_RIGHT);
	assign hit_status = addr_hit(paddr, `AMX_IDX_STATUS);
	assign wr_byte0   = access & pwrite & pstrb[0];

	// stored fields go to the decoder in path order
	assign lvl.code[`AMX_PATH_LL] = hi_field(st_r.lvl_left);
	assign lvl.code[`AMX_PATH_RL] = lo_field(st_r.lvl_left);
	assign lvl.code[`AMX_PATH_LR] = hi_field(st_r.lvl_right);
	assign lvl.code[`AMX_PATH_RR] = lo_field(st_r.lvl_right);

	amx_level_decode u_decode (
		.lvl (lvl)
	);

	// status shows decoded connections and reserved codes held
	always_comb begin
		status_val = '0;
		status_val[`AMX_ST_CONN_LSB +: `AMX_NPATH] = st_r.connect;
		status_val[`AMX_ST_RSVD_LSB +: `AMX_NPATH] = st_r.reserved;
	end

	// next state: bus answer, register writes, decoded outputs
	always_comb begin
		st_nxt = st_r;
		// answer is prepared in setup, shown for one access cycle
		st_nxt.pready = setup;
		if (setup) begin
			st_nxt.pslverr = ~(hit_left | hit_right | hit_status);
			if (pwrite) begin
				st_nxt.prdata = '0;
			end else if (hit_left) begin
				st_nxt.prdata = `AMX_DATA_W'(st_r.lvl_left);
			end else if (hit_right) begin
				st_nxt.prdata = `AMX_DATA_W'(st_r.lvl_right);
			end else if (hit_status) begin
				st_nxt.prdata = `AMX_DATA_W'(status_val);
			end else begin
				st_nxt.prdata = '0;
			end
		end else if (access) begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = '0;
		end
		// codes are stored as written, even reserved ones
		if (wr_byte0 && hit_left) begin
			st_nxt.lvl_left = pwdata[`AMX_REG_W-1:0];
		end
		if (wr_byte0 && hit_right) begin
			st_nxt.lvl_right = pwdata[`AMX_REG_W-1:0];
		end
		// decoded levels follow the stored fields one cycle later
		st_nxt.connect  = lvl.connect;
		st_nxt.atten    = lvl.atten;
		st_nxt.reserved = lvl.reserved;
	end

	// state register; every field starts disconnected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.lvl_left  <= `AMX_REG_RST;
			st_r.lvl_right <= `AMX_REG_RST;
			st_r.prdata    <= '0;
			st_r.pready    <= 1'b0;
			st_r.pslverr   <= 1'b0;
			st_r.connect   <= '0;
			st_r.atten     <= '0;
			st_r.reserved  <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign prdata                         = st_r.prdata;
	assign pready                         = st_r.pready;
	assign pslverr                        = st_r.pslverr;
	assign mix_connect                    = st_r.connect;
	assign left_adc_from_left_mic_atten   = st_r.atten[`AMX_PATH_LL];
	assign left_adc_from_right_mic_atten  = st_r.atten[`AMX_PATH_RL];
	assign right_adc_from_left_mic_atten  = st_r.atten[`AMX_PATH_LR];
	assign right_adc_from_right_mic_atten = st_r.atten[`AMX_PATH_RR];

endmodule // amx_mix_levels

/* File: sim/amx_mix_levels_properties.sv */
// assertion checker for the mix level register block
module amx_mix_levels_properties #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [3:0]        mix_connect,
	input wire logic [4:0]        left_adc_from_left_mic_atten,
	input wire logic [4:0]        left_adc_from_right_mic_atten,
	input wire logic [4:0]        right_adc_from_left_mic_atten,
	input wire logic [4:0]        right_adc_from_right_mic_atten
);
	timeunit 1ns;
	timeprecision 1ps;
	// completed writes to the two mix registers
	logic wr_l;
	logic wr_r;
	assign wr_l = psel && penable && pready && pwrite && pstrb[0]
		&& paddr == ADDR_W'(8'h44);
	assign wr_r = psel && penable && pready && pwrite && pstrb[0]
		&& paddr == ADDR_W'(8'h48);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (psel && !penable && !(paddr inside
		{ADDR_W'(8'h44), ADDR_W'(8'h48), ADDR_W'(8'h80)}) |=> pslverr)
		else $error("unmapped access without error");
	ll_level_a: assert property (wr_l && pwdata[7:4] <= 4'h8 |-> ##2
		mix_connect[0] && left_adc_from_left_mic_atten ==
		$past(pwdata[7:4], 2) * 5'h03) else $error("left to left level");
	rl_level_a: assert property (wr_l && pwdata[3:0] <= 4'h8 |-> ##2
		mix_connect[1] && left_adc_from_right_mic_atten ==
		$past(pwdata[3:0], 2) * 5'h03) else $error("right to left level");
	lr_level_a: assert property (wr_r && pwdata[7:4] <= 4'h8 |-> ##2
		mix_connect[2] && right_adc_from_left_mic_atten ==
		$past(pwdata[7:4], 2) * 5'h03) else $error("left to right level");
	rr_level_a: assert property (wr_r && pwdata[3:0] <= 4'h8 |-> ##2
		mix_connect[3] && right_adc_from_right_mic_atten ==
		$past(pwdata[3:0], 2) * 5'h03) else $error("right to right level");
	off_disc_a: assert property (wr_l && pwdata[7:4] == 4'hF |-> ##2
		!mix_connect[0] && left_adc_from_left_mic_atten == 5'h00)
		else $error("off code still connected");
endmodule // amx_mix_levels_properties

/* File: sim/testbench.sv */
// self-checking bench for the mix level register block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, mix_connect;
	logic [4:0]  left_adc_from_left_mic_atten, left_adc_from_right_mic_atten;
	logic [4:0]  right_adc_from_left_mic_atten, right_adc_from_right_mic_atten;
	int          num_errors, n_compared;

	amx_mix_levels #(.ADDR_W(12)) amx_mix_levels_inst (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .mix_connect, .left_adc_from_left_mic_atten,
		.left_adc_from_right_mic_atten, .right_adc_from_left_mic_atten,
		.right_adc_from_right_mic_atten);

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	// one apb transfer; waits an edge first so drives never collide
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never gets pready
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// both registers read back disconnected after reset
	task automatic t_reset();
		apb(1'b0, 12'h044, 32'h0, rd, err);
		chk(rd, 32'h000000FF);
		apb(1'b0, 12'h048, 32'h0, rd, err);
		chk(rd, 32'h000000FF);
		chk(32'(mix_connect), 32'h0);
		chk(32'(err), 32'h0);
		chk(32'(left_adc_from_left_mic_atten), 32'h0);
	endtask

	// every connecting level code 0 to 8 in every field, read back and decoded
	task automatic t_levels();
		for (int n = 0; n < 9; n++) begin
			apb(1'b1, 12'h044, {24'h0, 4'(n), 4'(8 - n)}, rd, err);
			apb(1'b1, 12'h048, {24'h0, 4'(8 - n), 4'(n)}, rd, err);
			apb(1'b0, 12'h044, 32'h0, rd, err);
			chk(rd, {24'h0, 4'(n), 4'(8 - n)});
			apb(1'b0, 12'h048, 32'h0, rd, err);
			chk(rd, {24'h0, 4'(8 - n), 4'(n)});
			chk(32'(mix_connect), 32'h0000000F);
			chk(32'(right_adc_from_right_mic_atten), 32'(n * 3));
			chk(32'(left_adc_from_left_mic_atten), 32'(n * 3));
			chk(32'(left_adc_from_right_mic_atten), 32'((8 - n) * 3));
			chk(32'(right_adc_from_left_mic_atten), 32'((8 - n) * 3));
		end
	endtask

	// off code in the left-to-left and right-to-right fields, then an unmapped read and a status read
	task automatic t_off();
		apb(1'b1, 12'h044, 32'h000000F0, rd, err);
		apb(1'b1, 12'h048, 32'h0000000F, rd, err);
		apb(1'b0, 12'h040, 32'h0, rd, err);
		chk(32'(err), 32'h1);
		chk(rd, 32'h0);
		chk(32'(mix_connect), 32'h6);
		chk(32'(left_adc_from_left_mic_atten), 32'h0);
		chk(32'(right_adc_from_right_mic_atten), 32'h0);
		apb(1'b0, 12'h080, 32'h0, rd, err);
		chk(rd, 32'h00000006);
		chk(32'(err), 32'h0);
	endtask

	// a write without pstrb[0] is dropped; a mid-run reset clears all
	task automatic t_strb_reset();
		pstrb <= 4'hE;
		apb(1'b1, 12'h044, 32'h00000000, rd, err);
		pstrb <= 4'hF;
		apb(1'b0, 12'h044, 32'h0, rd, err);
		chk(rd, 32'h000000F0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h044, 32'h0, rd, err);
		chk(rd, 32'h000000FF);
		apb(1'b0, 12'h048, 32'h0, rd, err);
		chk(rd, 32'h000000FF);
		chk(32'(mix_connect), 32'h0);
	endtask

	task automatic tally_and_finish();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog against a hung transfer
	initial begin
		repeat (3000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end

	// reset, then the scenarios
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_levels();
		t_off();
		t_strb_reset();
		tally_and_finish();
	end
endmodule // testbench

bind amx_mix_levels amx_mix_levels_properties #(.ADDR_W(ADDR_W)) props_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.pready, .pslverr, .mix_connect, .left_adc_from_left_mic_atten,
	.left_adc_from_right_mic_atten, .right_adc_from_left_mic_atten,
	.right_adc_from_right_mic_atten);
